// ---- src/mmf_consts.svh ----
// Constants for the serial master telegram engine
`ifndef MMF_CONSTS_SVH
`define MMF_CONSTS_SVH

`define MMF_CLK_MHZ        50
`define MMF_MS_US          1000
`define MMF_MS_CYCLES      (`MMF_MS_US * `MMF_CLK_MHZ)
`define MMF_RTU_GAP_US     1750
`define MMF_RTU_GAP_CYCLES (`MMF_RTU_GAP_US * `MMF_CLK_MHZ)
`define MMF_REPLY_MS_RST   16'h0064
`define MMF_FIFO_DEPTH     8
`define MMF_FIFO_WIDTH     9

`define MMF_FC_RD_OBITS    8'h01
`define MMF_FC_RD_IBITS    8'h02
`define MMF_FC_RD_OWORDS   8'h03
`define MMF_FC_RD_IWORDS   8'h04
`define MMF_FC_WR_OBIT     8'h05
`define MMF_FC_WR_OWORD    8'h06
`define MMF_FC_WR_OBITS    8'h0f
`define MMF_FC_WR_OWORDS   8'h10
`define MMF_EXC_BIT        7
`define MMF_FIXED_LAST     2'h3
`define MMF_MIN_RTU_BYTES  8'h04
`define MMF_MIN_ASC_BYTES  8'h03
`define MMF_DATA_FIRST     8'h04

`define MMF_CH_COLON       8'h3a
`define MMF_CH_CR          8'h0d
`define MMF_CH_LF          8'h0a
`define MMF_CH_ZERO        8'h30
`define MMF_CH_NINE        8'h39
`define MMF_CH_UA          8'h41
`define MMF_CH_UF          8'h46
`define MMF_CH_A_OFS       8'h37

`define MMF_CRC_INIT       16'hffff
`define MMF_CRC_POLY       16'ha001

`endif

// ---- src/mmf_pkg.sv ----
// Types of the serial master telegram engine
`default_nettype none
package mmf_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_ADDR, ST_FUNC, ST_PAY, ST_CHK_HI, ST_CHK_LO,
    ST_CR, ST_LF, ST_WAIT, ST_RX, ST_FLUSH, ST_DONE
  } mmf_state_t;
endpackage : mmf_pkg
`default_nettype wire

// ---- src/mmf_fifo.sv ----
// Payload FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "mmf_consts.svh"
module mmf_fifo #(
  parameter int WIDTH = `MMF_FIFO_WIDTH,
  parameter int DEPTH = `MMF_FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign push       = in_valid && in_ready;
  assign pop        = out_valid && out_ready;
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data   = mem[rd_ptr_reg];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready   <= 1'b1;
      out_valid  <= 1'b0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_next;
      in_ready  <= count_next != (AW+1)'(DEPTH);
      out_valid <= count_next != '0;
    end
  end
endmodule : mmf_fifo
`default_nettype wire

// ---- src/mmf_framer.sv ----
// Serial bus master: builds request telegrams and parses replies
// Behaviour
// - Wait reply delay; no other exchange meanwhile.
// - Only one outstanding transaction at a time.
// - Frame is address, function, data, check.
// - ASCII: two hex characters per byte, delimited.
// - RTU: one character per byte, idle-gap framing.
// - Transfer mode chosen by run-time configure call.
// - Codes 01h/02h read output/input bits.
// - Codes 03h/04h read output/input words.
// - Codes 05h/06h write single bit/word.
// - Codes 0Fh/10h write n bits/words.
// - Function code with 80h set means error.
// - Sixteen-bit fields go high byte first.
// - CRC in RTU, LRC in ASCII, both directions.
// - Bit read carries address, code, start, count, check.
// - Block acts as bus master only.
`timescale 1ns/1ps
`default_nettype none
`include "mmf_consts.svh"
module mmf_framer
  import mmf_pkg::*;
#(
  parameter int MS_CYCLES  = `MMF_MS_CYCLES,
  parameter int GAP_CYCLES = `MMF_RTU_GAP_CYCLES,
  parameter int FIFO_DEPTH = `MMF_FIFO_DEPTH
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        cfg_valid,
  input  wire logic        cfg_ascii,
  input  wire logic [15:0] cfg_reply_ms,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_slave,
  input  wire logic [7:0]  req_func,
  input  wire logic        pay_valid,
  output logic             pay_ready,
  input  wire logic [7:0]  pay_data,
  input  wire logic        pay_last,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  input  wire logic        tx_ready,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             resp_data_valid,
  output logic      [7:0]  resp_data,
  output logic             resp_valid,
  output logic             resp_exception,
  output logic             resp_rx_error,
  output logic             resp_timeout,
  output logic      [7:0]  resp_func
);
  localparam int MSW = $clog2(MS_CYCLES + 1);
  localparam int GW  = $clog2(GAP_CYCLES + 1);

  generate
    if (MS_CYCLES < 1 || GAP_CYCLES < 2 || FIFO_DEPTH < 2) begin : g_bad
      $error("timing counts or fifo depth out of range");
    end
  endgenerate

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? (`MMF_CH_ZERO + {4'h0, n}) : (`MMF_CH_A_OFS + {4'h0, n});
  endfunction : hex_char

  // Returns {bad, nibble}
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= `MMF_CH_ZERO && c <= `MMF_CH_NINE) hex_val = {1'b0, 4'(c - `MMF_CH_ZERO)};
    else if (c >= `MMF_CH_UA && c <= `MMF_CH_UF) hex_val = {1'b0, 4'(c - `MMF_CH_A_OFS)};
    else hex_val = 5'h10;
  endfunction : hex_val

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MMF_CRC_POLY) : (r >> 1);
    end
    crc_step = r;
  endfunction : crc_step

  function automatic logic is_fixed(input logic [7:0] f);
    is_fixed = f inside {`MMF_FC_RD_OBITS, `MMF_FC_RD_IBITS, `MMF_FC_RD_OWORDS,
                         `MMF_FC_RD_IWORDS, `MMF_FC_WR_OBIT, `MMF_FC_WR_OWORD};
  endfunction : is_fixed

  function automatic logic is_supported(input logic [7:0] f);
    is_supported = is_fixed(f) || f == `MMF_FC_WR_OBITS || f == `MMF_FC_WR_OWORDS;
  endfunction : is_supported

  mmf_state_t  state_reg;
  logic        ascii_reg;
  logic [15:0] reply_ms_reg;
  logic [7:0]  slave_reg;
  logic [7:0]  func_reg;
  logic        fixed_reg;
  logic [1:0]  fixed_cnt_reg;
  logic        nib_reg;
  logic [15:0] crc_reg;
  logic [7:0]  lrc_reg;
  logic [MSW-1:0] ms_div_reg;
  logic [15:0] ms_left_reg;
  logic [GW-1:0]  gap_reg;
  logic [7:0]  rx_cnt_reg;
  logic [7:0]  dly0_reg;
  logic [7:0]  dly1_reg;
  logic [3:0]  hi_reg;
  logic        half_reg;
  logic        bad_reg;
  logic [15:0] rx_crc_reg;
  logic [7:0]  rx_sum_reg;
  logic [7:0]  rx_addr_reg;
  logic [7:0]  rx_func_reg;

  logic        accept;
  logic        tx_free;
  logic        step;
  logic        byte_st;
  logic        byte_done;
  logic        pay_end;
  logic        listen;
  logic        rx_end;
  logic        chk_ok;
  logic        rx_stb;
  logic [7:0]  rx_byte;
  logic [4:0]  hv;
  logic [7:0]  src_byte;
  logic [7:0]  chr;
  logic [8:0]  f_data;
  logic        f_valid;
  logic        f_ready;

  mmf_fifo #(.WIDTH(`MMF_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (pay_valid),
    .in_ready  (pay_ready),
    .in_data   ({pay_last, pay_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  assign accept  = req_valid && req_ready;
  assign tx_free = !tx_valid || tx_ready;
  assign byte_st = state_reg inside {ST_ADDR, ST_FUNC, ST_PAY, ST_CHK_HI, ST_CHK_LO};
  assign step    = (state_reg inside {ST_START, ST_CR, ST_LF} || byte_st) && tx_free
                   && (state_reg != ST_PAY || f_valid);
  assign byte_done = step && byte_st && (!ascii_reg || nib_reg);
  assign pay_end = fixed_reg ? (fixed_cnt_reg == `MMF_FIXED_LAST) : f_data[8];
  assign f_ready = byte_done && state_reg == ST_PAY;
  assign listen  = state_reg == ST_WAIT || state_reg == ST_RX;
  assign rx_end  = ascii_reg ? (rx_valid && rx_data == `MMF_CH_LF)
                             : (!rx_valid && gap_reg == GW'(GAP_CYCLES - 1));
  assign chk_ok  = ascii_reg ? (rx_sum_reg == 8'h00 && rx_cnt_reg >= `MMF_MIN_ASC_BYTES)
                             : (rx_crc_reg == {dly1_reg, dly0_reg}
                                && rx_cnt_reg >= `MMF_MIN_RTU_BYTES);

  // Byte and character to send for the current frame field
  always_comb begin
    case (state_reg)
      ST_ADDR:   src_byte = slave_reg;
      ST_FUNC:   src_byte = func_reg;
      ST_PAY:    src_byte = f_data[7:0];
      ST_CHK_HI: src_byte = ascii_reg ? 8'(8'h00 - lrc_reg) : crc_reg[15:8];
      ST_CHK_LO: src_byte = crc_reg[7:0];
      default:   src_byte = 8'h00;
    endcase
    case (state_reg)
      ST_START: chr = `MMF_CH_COLON;
      ST_CR:    chr = `MMF_CH_CR;
      ST_LF:    chr = `MMF_CH_LF;
      default:  chr = ascii_reg ? hex_char(nib_reg ? src_byte[3:0] : src_byte[7:4])
                                : src_byte;
    endcase
  end

  // Received byte assembly
  always_comb begin
    hv      = hex_val(rx_data);
    rx_byte = rx_data;
    rx_stb  = 1'b0;
    if (rx_valid && listen) begin
      if (!ascii_reg) begin
        rx_stb = 1'b1;
      end else if (!hv[4] && half_reg) begin
        rx_stb  = 1'b1;
        rx_byte = {hi_reg, hv[3:0]};
      end
    end
  end

  // Mode and reply delay only change between exchanges
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ascii_reg    <= 1'b0;
      reply_ms_reg <= `MMF_REPLY_MS_RST;
    end else if (cfg_valid && state_reg == ST_IDLE) begin
      ascii_reg    <= cfg_ascii;
      reply_ms_reg <= cfg_reply_ms;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: if (accept) begin
          if (!is_supported(req_func)) state_reg <= ST_DONE;
          else state_reg <= ascii_reg ? ST_START : ST_ADDR;
        end
        ST_START:  if (step) state_reg <= ST_ADDR;
        ST_ADDR:   if (byte_done) state_reg <= ST_FUNC;
        ST_FUNC:   if (byte_done) state_reg <= ST_PAY;
        ST_PAY:    if (byte_done && pay_end) state_reg <= ST_CHK_HI;
        ST_CHK_HI: if (byte_done) state_reg <= ascii_reg ? ST_CR : ST_CHK_LO;
        ST_CHK_LO: if (byte_done) state_reg <= ST_WAIT;
        ST_CR:     if (step) state_reg <= ST_LF;
        ST_LF:     if (step) state_reg <= ST_WAIT;
        ST_WAIT: begin
          if (rx_valid) state_reg <= ST_RX;
          else if (ms_left_reg == 16'h0000) state_reg <= ST_DONE;
        end
        ST_RX:     if (rx_end) state_reg <= ST_FLUSH;
        ST_FLUSH:  state_reg <= ST_DONE;
        ST_DONE:   state_reg <= ST_IDLE;
        default:   state_reg <= ST_IDLE;
      endcase
    end
  end

  // New requests are held off until the exchange ends
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) req_ready <= 1'b1;
    else if (accept) req_ready <= 1'b0;
    else if (state_reg == ST_DONE) req_ready <= 1'b1;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      slave_reg <= 8'h00;
      func_reg  <= 8'h00;
      fixed_reg <= 1'b0;
    end else if (accept) begin
      slave_reg <= req_slave;
      func_reg  <= req_func;
      fixed_reg <= is_fixed(req_func);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
    end else if (step) begin
      tx_valid <= 1'b1;
      tx_data  <= chr;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // Transmit check accumulation over address, function and data
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      crc_reg       <= `MMF_CRC_INIT;
      lrc_reg       <= 8'h00;
      nib_reg       <= 1'b0;
      fixed_cnt_reg <= 2'h0;
    end else if (accept) begin
      crc_reg       <= `MMF_CRC_INIT;
      lrc_reg       <= 8'h00;
      nib_reg       <= 1'b0;
      fixed_cnt_reg <= 2'h0;
    end else begin
      if (step && byte_st && ascii_reg) nib_reg <= !nib_reg;
      if (byte_done && state_reg inside {ST_ADDR, ST_FUNC, ST_PAY}) begin
        crc_reg <= crc_step(crc_reg, src_byte);
        lrc_reg <= lrc_reg + src_byte;
      end
      if (f_ready) fixed_cnt_reg <= fixed_cnt_reg + 2'h1;
    end
  end

  // Millisecond divider for the reply delay, line idle counter
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ms_div_reg  <= '0;
      ms_left_reg <= `MMF_REPLY_MS_RST;
      gap_reg     <= '0;
    end else begin
      if (state_reg != ST_WAIT) begin
        ms_div_reg  <= '0;
        ms_left_reg <= reply_ms_reg;
      end else if (ms_div_reg == MSW'(MS_CYCLES - 1)) begin
        ms_div_reg <= '0;
        if (ms_left_reg != 16'h0000) ms_left_reg <= ms_left_reg - 16'h0001;
      end else begin
        ms_div_reg <= ms_div_reg + 1'b1;
      end
      if (rx_valid || state_reg != ST_RX) gap_reg <= '0;
      else if (gap_reg != GW'(GAP_CYCLES - 1)) gap_reg <= gap_reg + 1'b1;
    end
  end

  // Reply parsing; the last two bytes are held back, the check being both in RTU and only the last in ASCII
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_cnt_reg <= 8'h00;
      dly0_reg   <= 8'h00;
      dly1_reg   <= 8'h00;
      hi_reg     <= 4'h0;
      half_reg   <= 1'b0;
      bad_reg    <= 1'b0;
      rx_crc_reg <= `MMF_CRC_INIT;
      rx_sum_reg <= 8'h00;
      rx_addr_reg <= 8'h00;
      rx_func_reg <= 8'h00;
    end else if (accept || (ascii_reg && listen && rx_valid && rx_data == `MMF_CH_COLON)) begin
      rx_cnt_reg <= 8'h00;
      half_reg   <= 1'b0;
      bad_reg    <= 1'b0;
      rx_crc_reg <= `MMF_CRC_INIT;
      rx_sum_reg <= 8'h00;
    end else if (rx_valid && listen) begin
      if (ascii_reg && rx_data != `MMF_CH_CR && rx_data != `MMF_CH_LF) begin
        if (hv[4]) bad_reg <= 1'b1;
        else begin
          half_reg <= !half_reg;
          if (!half_reg) hi_reg <= hv[3:0];
        end
      end
      if (rx_stb) begin
        if (rx_cnt_reg != 8'hff) rx_cnt_reg <= rx_cnt_reg + 8'h01;
        dly0_reg   <= rx_byte;
        dly1_reg   <= dly0_reg;
        rx_sum_reg <= rx_sum_reg + rx_byte;
        if (rx_cnt_reg == 8'h00) rx_addr_reg <= rx_byte;
        if (rx_cnt_reg == 8'h01) rx_func_reg <= rx_byte;
        if (rx_cnt_reg >= 8'h02) rx_crc_reg <= crc_step(rx_crc_reg, dly1_reg);
      end
    end
  end

  // Data bytes of a reply from the addressed slave only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      resp_data_valid <= 1'b0;
      resp_data       <= 8'h00;
    end else begin
      resp_data_valid <= 1'b0;
      if (rx_addr_reg == slave_reg && rx_cnt_reg >= `MMF_DATA_FIRST
          && (rx_stb || (state_reg == ST_FLUSH && ascii_reg))) begin
        resp_data_valid <= 1'b1;
        resp_data       <= dly1_reg;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      resp_valid     <= 1'b0;
      resp_exception <= 1'b0;
      resp_rx_error  <= 1'b0;
      resp_timeout   <= 1'b0;
      resp_func      <= 8'h00;
    end else begin
      resp_valid <= state_reg == ST_DONE;
      if (accept) begin
        resp_exception <= 1'b0;
        resp_rx_error  <= !is_supported(req_func);
        resp_timeout   <= 1'b0;
        resp_func      <= 8'h00;
      end else if (state_reg == ST_WAIT && !rx_valid && ms_left_reg == 16'h0000) begin
        resp_timeout <= 1'b1;
      end else if (state_reg == ST_FLUSH) begin
        resp_func      <= rx_func_reg;
        resp_rx_error  <= bad_reg || half_reg || !chk_ok
                          || rx_addr_reg != slave_reg
                          || rx_func_reg[6:0] != func_reg[6:0];
        resp_exception <= rx_func_reg[`MMF_EXC_BIT] && chk_ok && !bad_reg && !half_reg
                          && rx_addr_reg == slave_reg
                          && rx_func_reg[6:0] == func_reg[6:0];
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  one_outstanding_a:
    assert property (accept |-> state_reg == ST_IDLE ##1 !req_ready)
      else $error("request taken while an exchange is open");
  reply_wait_a:
    assert property ((state_reg == ST_WAIT && !rx_valid && ms_left_reg != 16'h0000)
                     |=> state_reg == ST_WAIT && !req_ready)
      else $error("left reply wait before delay ended");
  reply_timeout_a:
    assert property ((state_reg == ST_WAIT && !rx_valid && ms_left_reg == 16'h0000)
                     |=> ##1 resp_valid && resp_timeout)
      else $error("reply timeout not reported");
  frame_order_a:
    assert property ($rose(state_reg == ST_FUNC) |-> $past(state_reg) == ST_ADDR)
      else $error("function code not after address");
  ascii_start_a:
    assert property ((step && state_reg == ST_START) |=> tx_valid && tx_data == `MMF_CH_COLON)
      else $error("ascii frame lacks start character");
  rtu_no_delim_a:
    assert property (state_reg inside {ST_START, ST_CR, ST_LF} |-> ascii_reg)
      else $error("delimiter sent in rtu mode");
  mode_stable_a:
    assert property (state_reg != ST_IDLE |=> $stable(ascii_reg))
      else $error("transfer mode changed during exchange");
  crc_order_a:
    assert property ($rose(state_reg == ST_CHK_LO)
                     |-> $past(state_reg) == ST_CHK_HI && !ascii_reg)
      else $error("check low byte out of order");
  fixed_len_a:
    assert property ((f_ready && fixed_reg && fixed_cnt_reg == `MMF_FIXED_LAST)
                     |=> state_reg == ST_CHK_HI)
      else $error("fixed request not four payload bytes");
  exception_a:
    assert property (resp_exception |-> resp_func[`MMF_EXC_BIT] && !resp_rx_error)
      else $error("exception without error bit");
  addr_check_a:
    assert property ((state_reg == ST_FLUSH && rx_addr_reg != slave_reg)
                     |=> ##1 resp_valid && resp_rx_error)
      else $error("foreign reply not flagged");

  ascii_done_c:   cover property (resp_valid && ascii_reg && !resp_rx_error);
  rtu_done_c:     cover property (resp_valid && !ascii_reg && !resp_rx_error && !resp_timeout);
  exception_c:    cover property (resp_valid && resp_exception);
  timeout_c:      cover property (resp_valid && resp_timeout);
endmodule : mmf_framer
`default_nettype wire

// ---- verification/mmf_slave_model.sv ----
// Slave station model on the serial side of the telegram engine
`timescale 1ns/1ps
`default_nettype none
module mmf_slave_model (
  input  wire logic       clock,
  input  wire logic       ascii,
  input  wire logic       slow,
  input  wire logic       silent,
  input  wire logic       exc,
  input  wire logic       bad_chk,
  input  wire logic       wrong_adr,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_data
);
  logic [7:0] ch[$];
  logic [7:0] got[$];
  logic       frame_ok;
  int         nchars = 0;
  function automatic logic [15:0] crc(input logic [7:0] b[$], input int n);
    logic [15:0] c = 16'hffff;
    for (int i = 0; i < n; i++) begin
      c ^= {8'h00, b[i]};
      for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc
  function automatic logic [7:0] lrc(input logic [7:0] b[$]);
    logic [7:0] s = 8'h00;
    foreach (b[i]) s += b[i];
    return -s;
  endfunction : lrc
  function automatic logic [7:0] hexc(input logic [3:0] v);
    return v > 4'h9 ? 8'h37 + v : 8'h30 + v;
  endfunction : hexc
  function automatic logic [3:0] nib(input logic [7:0] c);
    return c[3:0] + (c[6] ? 4'h9 : 4'h0);
  endfunction : nib
  task automatic send(input logic [7:0] c);
    @(negedge clock);
    rx_valid = 1'b1;
    rx_data = c;
    @(negedge clock);
    rx_valid = 1'b0;
    rx_data = ~c;  // Released line does not keep its last value
  endtask : send
  always @(negedge clock) tx_ready <= slow ? !tx_ready : 1'b1;
  initial begin
    int idle;
    logic [7:0] r[$];
    logic [15:0] k;
    logic [7:0] cap[$];
    rx_valid = 1'b0;
    rx_data = 8'h00;
    forever begin
      cap = {};
      idle = 0;
      while (cap.size() == 0 || (ascii ? cap[$] != 8'h0a : idle < 4)) begin
        @(posedge clock);
        if (tx_valid && tx_ready) begin
          cap.push_back(tx_data);
          nchars++;
          idle = 0;
        end else if (!tx_valid) idle++;
      end
      // Last request stays visible to the bench until the next one arrives
      ch = cap;
      got = {};
      if (ascii) begin
        frame_ok = ch[0] == 8'h3a && ch[$-1] == 8'h0d;
        for (int i = 1; i < ch.size() - 2; i++) begin
          frame_ok &= ch[i] inside {[8'h30:8'h39], [8'h41:8'h46]};
          if (i[0]) got.push_back({nib(ch[i]), nib(ch[i+1])});
        end
        frame_ok &= lrc(got) == 8'h00;
        void'(got.pop_back());
      end else begin
        frame_ok = crc(ch, ch.size() - 2) == {ch[$-1], ch[$]};
        got = ch[0:$-2];
      end
      if (!silent) begin
        r = got;
        r[1] |= exc ? 8'h80 : 8'h00;
        r[0] ^= wrong_adr ? 8'h01 : 8'h00;
        k = crc(r, r.size()) ^ {15'h0000, bad_chk};
        if (ascii) r.push_back(lrc(r) ^ {7'h00, bad_chk});
        else r = {r, k[15:8], k[7:0]};
        if (ascii) send(8'h3a);
        foreach (r[i]) begin
          if (ascii) begin
            send(hexc(r[i][7:4]));
            send(hexc(r[i][3:0]));
          end else send(r[i]);
        end
        if (ascii) begin
          send(8'h0d);
          send(8'h0a);
        end
      end
    end
  end
endmodule : mmf_slave_model
`default_nettype wire

// ---- verification/test_modbus_master_framer.sv ----
// Self-checking bench for the serial master telegram engine
`timescale 1ns/1ps
`default_nettype none
module test_modbus_master_framer;
  logic        clock, resetn, cfg_valid, cfg_ascii, req_valid, req_ready, pay_valid;
  logic        pay_ready, pay_last, tx_valid, tx_ready, rx_valid, resp_data_valid, resp_valid;
  logic        resp_exception, resp_rx_error, resp_timeout, slow, silent, exc, bad_chk, wrong_adr;
  logic [15:0] cfg_reply_ms;
  logic [7:0]  req_slave, req_func, pay_data, tx_data, rx_data, resp_data, resp_func;
  logic [7:0]  rq[$];
  logic [3:0]  flags;
  int          fails = 0, comparisons = 0, wait_n;
  mmf_framer #(.MS_CYCLES(10), .GAP_CYCLES(8)) dut (.clock, .resetn, .cfg_valid, .cfg_ascii,
    .cfg_reply_ms, .req_valid, .req_ready, .req_slave, .req_func, .pay_valid, .pay_ready,
    .pay_data, .pay_last, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data, .resp_data_valid,
    .resp_data, .resp_valid, .resp_exception, .resp_rx_error, .resp_timeout, .resp_func);
  mmf_slave_model slave (.clock, .ascii(cfg_ascii), .slow, .silent, .exc, .bad_chk,
    .wrong_adr, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (resp_data_valid) rq.push_back(resp_data);
    if (resp_valid) flags = {resp_exception, resp_rx_error, resp_timeout, 1'b1};
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic cfg(input logic a, input logic [15:0] ms);
    cfg_valid = 1'b1;
    cfg_ascii = a;
    cfg_reply_ms = ms;
    @(negedge clock);
    cfg_valid = 1'b0;
  endtask : cfg
  task automatic push(input logic [7:0] b, input logic l);
    @(negedge clock);
    pay_valid = 1'b1;
    pay_data = b;
    pay_last = l;
    @(posedge clock);
    while (!pay_ready) @(posedge clock);
    @(negedge clock);
    pay_valid = 1'b0;
  endtask : push
  task automatic xfer(input logic [7:0] f, input logic [7:0] p, input logic fill);
    rq = {};
    if (fill) for (int k = 0; k < 4; k++) push(p + 8'(k), k == 3);
    req_valid = 1'b1;
    req_slave = 8'h11;
    req_func = f;
    @(posedge clock);
    while (!req_ready) @(posedge clock);
    @(negedge clock);
    req_valid = 1'b0;
    flags = 4'h0;
    wait_n = 0;
    while (!flags[0] && wait_n < 3000) begin
      @(negedge clock);
      wait_n++;
    end
    chk("answer", 16'(flags[0]), 16'h0001);
  endtask : xfer
  task automatic good(input logic [7:0] f, input logic [7:0] p);
    chk("frame check", 16'(slave.frame_ok), 16'h0001);
    chk("request length", 16'(slave.got.size()), 16'h0006);
    chk("request head", {slave.got[0], slave.got[1]}, {8'h11, f});
    chk("reply function", 16'(resp_func), 16'(f));
    chk("flags", 16'(flags), 16'h0001);
    chk("reply length", 16'(rq.size()), 16'h0004);
    for (int k = 0; k < 4; k++) begin
      chk("request body", 16'(slave.got[k+2]), 16'(p + 8'(k)));
      chk("reply body", 16'(rq[k]), 16'(p + 8'(k)));
    end
  endtask : good
  task automatic s_codes();
    logic [7:0] codes[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10};
    foreach (codes[i]) begin
      xfer(codes[i], 8'(i * 16 + 1), 1'b1);
      good(codes[i], 8'(i * 16 + 1));
      chk("rtu chars", 16'(slave.ch.size()), 16'h0008);
    end
  endtask : s_codes
  task automatic s_ascii();
    cfg(1'b1, 16'h0064);
    xfer(8'h03, 8'hc4, 1'b1);
    good(8'h03, 8'hc4);
    chk("ascii chars", 16'(slave.ch.size()), 16'h0011);
    cfg(1'b0, 16'h0064);
  endtask : s_ascii
  task automatic s_errors();
    exc = 1'b1;
    xfer(8'h06, 8'h5a, 1'b1);
    chk("error reply", {flags, 4'h0, resp_func}, 16'h9086);
    exc = 1'b0;
    bad_chk = 1'b1;
    xfer(8'h10, 8'ha5, 1'b1);
    chk("bad check", 16'(flags), 16'h0005);
    bad_chk = 1'b0;
    wrong_adr = 1'b1;
    xfer(8'h05, 8'h21, 1'b1);
    chk("foreign reply", {flags, 4'h0, 8'(rq.size())}, 16'h5000);
    wrong_adr = 1'b0;
  endtask : s_errors
  task automatic s_timeout();
    silent = 1'b1;
    cfg(1'b0, 16'h0002);
    xfer(8'h04, 8'h33, 1'b1);
    chk("timeout", 16'(flags), 16'h0003);
    chk("delay kept", 16'(wait_n > 20), 16'h0001);
    silent = 1'b0;
    cfg(1'b0, 16'h0064);
  endtask : s_timeout
  task automatic s_unsup();
    int n0;
    n0 = slave.nchars;
    xfer(8'h07, 8'h00, 1'b0);
    chk("unsupported", 16'(flags), 16'h0005);
    chk("nothing sent", 16'(slave.nchars - n0), 16'h0000);
  endtask : s_unsup
  task automatic s_fifo();
    slow = 1'b1;
    for (int k = 0; k < 8; k++) push(8'h70 + 8'(k), k[1:0] == 2'h3);
    chk("fifo full", 16'(pay_ready), 16'h0000);
    xfer(8'h01, 8'h70, 1'b0);
    good(8'h01, 8'h70);
    xfer(8'h02, 8'h74, 1'b0);
    good(8'h02, 8'h74);
    chk("fifo drained", 16'(pay_ready), 16'h0001);
    slow = 1'b0;
  endtask : s_fifo
  initial begin
    #400000;
    fails++;
    complete_run();
  end
  initial begin
    {resetn, cfg_valid, cfg_ascii, req_valid, pay_valid, pay_last, slow, silent, exc} = '0;
    {bad_chk, wrong_adr, flags, req_slave, req_func, pay_data} = '0;
    cfg_reply_ms = 16'h0064;
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    chk("idle outputs", {req_ready, pay_ready, tx_valid, resp_valid}, 16'h000c);
    s_codes();
    s_ascii();
    s_errors();
    s_timeout();
    s_unsup();
    s_fifo();
    complete_run();
  end
endmodule : test_modbus_master_framer
`default_nettype wire
